// ---- verilog/tppg_core.sv ----
// Three-phase PWM generator with APB register access
`timescale 1ns/1ps
`include "tppg_map.svh"

// Functional notes
// RULE_01 - Free-running 12-bit up/down counter driven through the prescaler.
// RULE_02 - Three 13-bit phase compare values set U, V and W duty.
// RULE_03 - 12-bit carrier compare sets turnaround point and shared period.
// RULE_04 - Each compare has a preload copy moved to active only at update.
// RULE_05 - Prescaler divides the clock by 1 to 8 via a 3-bit field.
// RULE_06 - Divider setting is buffered and takes effect after next update.
// RULE_07 - Mode bit: 1 selects centre-aligned, 0 selects edge-aligned.
// RULE_08 - Centre mode counts up to carrier, down to zero, repeats.
// RULE_09 - Centre mode: output low on up match, high on down match.
// RULE_10 - Output held high when compare exceeds zero-extended carrier.
// RULE_11 - Output held low whenever compare equals zero.
// RULE_12 - Edge mode counts up to carrier, clears; low on match, high on clear.
// RULE_13 - Matching uses counter zero-extended to thirteen bits.
// RULE_14 - 12-bit format: low byte then high byte; transfer waits for high.
// RULE_15 - 8-bit format: all compares 8 bits, loaded by one byte write.
// RULE_16 - 8-bit format: force bits give 100% duty, cleared at each update.
// RULE_17 - Reads of buffered registers return the preload copy.
// RULE_18 - Phase compare left-aligned in 16 bits, rounded into 13 bits.
// RULE_19 - Software never writes carrier compare as zero.
// RULE_20 - Centre mode can reload at both overflow and underflow.
// RULE_21 - Routing bit sends only U to six-step path or all three out.
// RULE_22 - Transfers only when repetition down-counter is zero; auto-reload.
// RULE_23 - Update flag raised with each update event.
// RULE_24 - Enable clear holds counter at zero; setting it forces transfer.
// RULE_25 - Writing FFh to status resets counter, transfers, sets update flag.
// RULE_26 - Prescaler yields a one-cycle count enable on the bus clock.
module tppg_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM outputs
  output logic six_step_pwm,
  output logic [2:0] phase_pwm,
  output logic update_event
);

  logic cke;
  logic cke_d;
  logic three_phase_route_sel;
  tppg_pkg::tppg_ctrl_type ctrl_pre;
  tppg_pkg::tppg_ctrl_type ctrl_act;
  logic [7:0] repetition_reload;
  logic [7:0] rep_cnt;
  logic update_flag;
  logic [15:0] cmp_raw [4];
  logic [3:0] cmp_rdy;
  logic [11:0] carrier_act;
  logic [12:0] phase_act [3];
  logic [2:0] pre_cnt;
  logic [11:0] cnt;
  tppg_pkg::tppg_dir_type dir;
  logic [2:0] phase_lvl;
  logic [2:0] next_phase_lvl;
  logic [31:0] next_prdata;

  // Bus decode
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire sel_ctrl = paddr == `TPPG_OFF_CTRL;
  wire sel_pwmctrl = paddr == `TPPG_OFF_PWMCTRL;
  wire sel_rep = paddr == `TPPG_OFF_REP;
  wire sel_isr = paddr == `TPPG_OFF_ISR;
  wire sel_status = paddr == `TPPG_OFF_STATUS;
  wire sel_cmp = (paddr[7:4] == `TPPG_OFF_CMP_BASE) && (paddr[1:0] == 2'h0);
  wire [1:0] cmp_idx = paddr[3:2];
  wire mapped = sel_ctrl | sel_pwmctrl | sel_rep | sel_isr | sel_status |
    sel_cmp;
  wire wr_lo = wr & pstrb[0];
  wire wr_hi = wr & pstrb[1];
  wire resync = wr_lo & sel_isr & (pwdata[7:0] == `TPPG_ISR_RESYNC);
  wire flag_clr = wr_lo & sel_isr & ~pwdata[`TPPG_ISR_UPDATE];

  // Counter sequencing
  wire centre = ctrl_act.centre_align_sel;
  wire tick = cke & (pre_cnt == ctrl_act.counter_divider_sel); // RULE_26
  wire at_top = cnt == carrier_act;
  wire going_up = dir == tppg_pkg::TPPG_UP;
  wire ovf_ev = tick & at_top & (~centre | going_up);
  wire unf_ev = tick & centre & ~going_up & (cnt == 12'h000); // RULE_20
  wire cnt_ev = ovf_ev | unf_ev;
  wire rep_zero = rep_cnt == 8'h00;
  wire upd_ev = cnt_ev & rep_zero; // RULE_22
  wire force_upd = (cke & ~cke_d) | resync; // RULE_24 RULE_25
  wire do_upd = upd_ev | force_upd; // RULE_04
  wire fmt8 = ctrl_pre.byte_format_sel;
  wire [12:0] cnt_ext = {1'b0, cnt}; // RULE_13
  wire [12:0] carrier_ext = {1'b0, carrier_act};

  // Round the left-aligned phase value into 13 bits, saturating
  function automatic logic [12:0] tppg_round(input logic [15:0] raw);
    logic [13:0] sum;
    sum = {1'b0, raw[`TPPG_CMP_MSB:3]} + {13'h0000, raw[`TPPG_CMP_LSB_ROUND]};
    tppg_round = sum[13] ? `TPPG_CMP13_MAX : sum[12:0]; // RULE_18
  endfunction : tppg_round

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // One wait state lets read data come straight from a flip-flop
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= next_prdata;
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    if (psel & penable & ~pready & ~pwrite) begin
      if (sel_ctrl) begin
        next_prdata[`TPPG_CTRL_CKE] = cke;
        next_prdata[`TPPG_CTRL_ROUTE] = three_phase_route_sel;
      end
      if (sel_pwmctrl) begin
        next_prdata[7:0] = ctrl_pre; // RULE_17
      end
      if (sel_rep) begin
        next_prdata[7:0] = repetition_reload; // RULE_17
      end
      if (sel_isr) begin
        next_prdata[`TPPG_ISR_UPDATE] = update_flag;
      end
      if (sel_cmp) begin
        next_prdata[15:0] = cmp_raw[cmp_idx]; // RULE_17
      end
      if (sel_status) begin
        next_prdata[11:0] = cnt;
        next_prdata[12] = ~going_up;
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke <= 1'b0;
      cke_d <= 1'b0;
      three_phase_route_sel <= 1'b0;
      repetition_reload <= `TPPG_RST_REP;
    end else begin
      cke_d <= cke;
      if (wr_lo & sel_ctrl) begin
        cke <= pwdata[`TPPG_CTRL_CKE];
        three_phase_route_sel <= pwdata[`TPPG_CTRL_ROUTE];
      end
      if (wr_lo & sel_rep) begin
        repetition_reload <= pwdata[7:0];
      end
    end
  end

  // Buffered PWM control; software write wins over the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pre <= `TPPG_RST_PWMCTRL;
      ctrl_act <= `TPPG_RST_PWMCTRL;
    end else begin
      if (wr_lo & sel_pwmctrl) begin
        ctrl_pre <= pwdata[7:0];
      end else if (do_upd) begin
        ctrl_pre.full_duty_force <= 3'h0; // RULE_16
      end
      if (do_upd) begin
        ctrl_act <= ctrl_pre; // RULE_06
      end
    end
  end

  // Update flag: a new update beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_flag <= 1'b0;
    end else if (do_upd) begin
      update_flag <= 1'b1; // RULE_23 RULE_25
    end else if (flag_clr) begin
      update_flag <= 1'b0;
    end
  end

  // Compare preloads with byte-order tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cmp_raw[i] <= `TPPG_RST_CMP;
      end
      cmp_rdy <= `TPPG_RST_CMP_RDY;
    end else if (sel_cmp & (wr_lo | wr_hi)) begin
      if (wr_lo) begin
        cmp_raw[cmp_idx][7:0] <= pwdata[7:0];
      end
      if (wr_hi & ~fmt8) begin
        cmp_raw[cmp_idx][15:8] <= pwdata[15:8];
      end
      // In 12-bit format a lone low byte holds the value back until its high byte lands
      cmp_rdy[cmp_idx] <= fmt8 | wr_hi; // RULE_14 RULE_15
    end
  end

  // Active compares
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_act <= 12'h000;
      for (int i = 0; i < 3; i++) begin
        phase_act[i] <= 13'h0000;
      end
    end else if (do_upd) begin
      if (cmp_rdy[`TPPG_CMP_CARRIER]) begin
        carrier_act <= fmt8 ? {4'h0, cmp_raw[0][7:0]} :
          cmp_raw[0][11:0]; // RULE_03 RULE_15
      end
      for (int i = 0; i < 3; i++) begin
        if (cmp_rdy[i + 1]) begin
          phase_act[i] <= fmt8 ?
            {4'h0, ctrl_pre.full_duty_force[i], cmp_raw[i + 1][7:0]} :
            tppg_round(cmp_raw[i + 1]); // RULE_02 RULE_16
        end
      end
    end
  end

  // Prescaler and repetition counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 3'h0;
      rep_cnt <= 8'h00;
    end else begin
      if (~cke | tick | resync) begin
        pre_cnt <= 3'h0; // RULE_05
      end else begin
        pre_cnt <= pre_cnt + 3'h1;
      end
      if (force_upd | upd_ev) begin
        rep_cnt <= repetition_reload; // RULE_22
      end else if (cnt_ev) begin
        rep_cnt <= rep_cnt - 8'h01;
      end
    end
  end

  // Main counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 12'h000;
      dir <= tppg_pkg::TPPG_UP;
    end else if (~cke | resync) begin
      cnt <= 12'h000; // RULE_24 RULE_25
      dir <= tppg_pkg::TPPG_UP;
    end else if (tick) begin
      case (dir)
        tppg_pkg::TPPG_UP: begin
          if (at_top & ~centre) begin
            cnt <= 12'h000; // RULE_12
          end else if (at_top) begin
            // Zero carrier is not allowed; the guard only avoids a wrap
            cnt <= (cnt == 12'h000) ? 12'h000 : cnt - 12'h001; // RULE_08
            dir <= tppg_pkg::TPPG_DOWN;
          end else begin
            cnt <= cnt + 12'h001; // RULE_01
          end
        end
        tppg_pkg::TPPG_DOWN: begin
          if (~centre) begin
            cnt <= 12'h000;
            dir <= tppg_pkg::TPPG_UP;
          end else if (cnt == 12'h000) begin
            cnt <= (carrier_act == 12'h000) ? 12'h000 : 12'h001; // RULE_08
            dir <= tppg_pkg::TPPG_UP;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        default: begin
          cnt <= 12'h000;
          dir <= tppg_pkg::TPPG_UP;
        end
      endcase
    end
  end

  // Per-phase output level
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      wire match = cnt_ext == phase_act[g]; // RULE_13
      wire hold_low = phase_act[g] == 13'h0000;
      wire hold_high = phase_act[g] > carrier_ext;
      wire edge_lvl = match ? 1'b0 :
        (cnt == 12'h000) ? 1'b1 : phase_lvl[g]; // RULE_12
      wire centre_lvl = match ? ~going_up : phase_lvl[g]; // RULE_09
      assign next_phase_lvl[g] = hold_low ? 1'b0 : // RULE_11
        hold_high ? 1'b1 : // RULE_10
        ~tick ? phase_lvl[g] :
        centre ? centre_lvl : edge_lvl; // RULE_07
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_lvl <= 3'h0;
    end else begin
      phase_lvl <= next_phase_lvl;
    end
  end

  // Output routing, registered so every output leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six_step_pwm <= 1'b0;
      phase_pwm <= 3'h0;
      update_event <= 1'b0;
    end else begin
      six_step_pwm <= ~three_phase_route_sel & phase_lvl[0]; // RULE_21
      phase_pwm <= three_phase_route_sel ? phase_lvl : 3'h0; // RULE_21
      update_event <= do_upd;
    end
  end

endmodule : tppg_core

// ---- verilog/tppg_map.svh ----
// Register offsets, field positions and reset values of the PWM generator
`ifndef TPPG_MAP_SVH
`define TPPG_MAP_SVH

`define TPPG_OFF_CTRL 8'h00
`define TPPG_OFF_PWMCTRL 8'h04
`define TPPG_OFF_REP 8'h08
`define TPPG_OFF_ISR 8'h0c
`define TPPG_OFF_CMP_BASE 4'h1
`define TPPG_OFF_STATUS 8'h20

`define TPPG_CTRL_CKE 0
`define TPPG_CTRL_ROUTE 1

`define TPPG_ISR_UPDATE 7
`define TPPG_ISR_RESYNC 8'hff

`define TPPG_CMP_CARRIER 2'h0
`define TPPG_CMP_LSB_ROUND 2
`define TPPG_CMP_MSB 15

`define TPPG_RST_CTRL 2'h0
`define TPPG_RST_PWMCTRL 8'h00
`define TPPG_RST_REP 8'h00
`define TPPG_RST_CMP 16'h0000
`define TPPG_RST_CMP_RDY 4'hf

`define TPPG_CNT_MAX 12'hfff
`define TPPG_CMP13_MAX 13'h1fff

`endif

// ---- verilog/tppg_pkg.sv ----
// Types shared by the PWM generator
package tppg_pkg;

  typedef enum logic [1:0] {
    TPPG_UP = 2'b01,
    TPPG_DOWN = 2'b10
  } tppg_dir_type;

  // Buffered PWM control fields, packed in register bit order
  typedef struct packed {
    logic [2:0] full_duty_force;
    logic byte_format_sel;
    logic centre_align_sel;
    logic [2:0] counter_divider_sel;
  } tppg_ctrl_type;

endpackage : tppg_pkg

// ---- testbench/tppg_chan_model.sv ----
// Channel manager stand-in that counts high cycles of each PWM line
`timescale 1ns/1ps
module tppg_chan_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Measurement window
  input wire logic meas,
  // PWM lines from the generator
  input wire logic six_step_pwm,
  input wire logic [2:0] phase_pwm,
  // High counts: [0] six-step, [1] U, [2] V, [3] W
  output logic [3:0][15:0] hi_cnt
);
  wire [3:0] lvl = {phase_pwm, six_step_pwm};
  // Counts clear outside a window so each window starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= '0;
    end else if (!meas) begin
      hi_cnt <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        hi_cnt[i] <= hi_cnt[i] + {15'h0, lvl[i]};
      end
    end
  end
endmodule : tppg_chan_model

// ---- testbench/tppg_monitor.sv ----
// Port assertions for the PWM generator
`timescale 1ns/1ps
module tppg_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // PWM
  input wire logic six_step_pwm,
  input wire logic [2:0] phase_pwm,
  input wire logic update_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_q;
  wire wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (wr_done && paddr == 8'h00) begin
      en_q <= pwdata[0];
    end
  end
  sequence s_en_rise;
    wr_done && paddr == 8'h00 && pwdata[0] && !en_q;
  endsequence
  sequence s_resync;
    wr_done && paddr == 8'h0c && pwdata[7:0] == 8'hff;
  endsequence
  sequence s_update;
    ##[1:4] update_event;
  endsequence
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> psel && $past(penable))
    else $error("pready without access");
  a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h20))
    else $error("pslverr wrong for address");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_route_excl: assert property (!(six_step_pwm && |phase_pwm))
    else $error("both PWM paths active");
  a_enable_update: assert property (s_en_rise |-> s_update)
    else $error("no update after enable");
  a_resync_update: assert property (s_resync |-> s_update)
    else $error("no update after resync");
endmodule : tppg_monitor

bind tppg_core tppg_monitor tppg_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .six_step_pwm(six_step_pwm),
  .phase_pwm(phase_pwm), .update_event(update_event));

// ---- testbench/tppg_core_tb_top.sv ----
// Register and duty tests of the PWM generator
`timescale 1ns/1ps
module tppg_core_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic meas = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, six_step_pwm, update_event, er;
  logic [2:0] phase_pwm;
  logic [3:0][15:0] hi_cnt;
  int n_fail = 0;
  int num_checks = 0;
  initial forever #5 pclk = ~pclk;
  tppg_core tppg_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .six_step_pwm(six_step_pwm), .phase_pwm(phase_pwm),
    .update_event(update_event));
  tppg_chan_model tppg_chan_model_inst (.pclk(pclk), .presetn(presetn),
    .meas(meas), .six_step_pwm(six_step_pwm), .phase_pwm(phase_pwm),
    .hi_cnt(hi_cnt));
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // Called just after a rising edge; leaves one idle cycle at the end
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
      input string m);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e, m);
  endtask : rdchk
  // Low byte first, then high byte
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {24'h0, v[7:0]}, 4'h1);
    apb(1'b1, a, {16'h0, v[15:8], 8'h0}, 4'h2);
  endtask : wr16
  task automatic duty(input int n, input logic [3:0][15:0] ex,
      input string t);
    meas <= 1'b1;
    repeat (n) @(posedge pclk);
    meas <= 1'b0;
    #1;
    for (int i = 0; i < 4; i++) begin
      chk({16'h0, hi_cnt[i]}, {16'h0, ex[i]}, "high count");
    end
    @(posedge pclk);
    $display("test %s done", t);
  endtask : duty
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #300000;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) begin
      rdchk(8'(a), 32'h0, "reset value");
    end
    apb(1'b0, 8'h40, 32'h0, 4'hf);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    apb(1'b1, 8'h0c, 32'hff, 4'h1);
    rdchk(8'h0c, 32'h80, "flag set");
    apb(1'b1, 8'h0c, 32'h7f, 4'h1);
    rdchk(8'h0c, 32'h0, "flag clear");
    $display("test resync done");
    // Carrier of 9 keeps the period short; never program zero
    wr16(8'h10, 16'h0009);
    wr16(8'h14, 16'h0024);
    wr16(8'h18, 16'h0000);
    wr16(8'h1c, 16'hf800);
    rdchk(8'h14, 32'h24, "preload readback");
    apb(1'b1, 8'h00, 32'h3, 4'h1);
    repeat (30) @(posedge pclk);
    duty(100, {16'd100, 16'd0, 16'd50, 16'd0}, "edge");
    apb(1'b1, 8'h04, 32'h08, 4'h1);
    repeat (50) @(posedge pclk);
    duty(180, {16'd180, 16'd0, 16'd100, 16'd0}, "centre");
    apb(1'b1, 8'h04, 32'h01, 4'h1);
    repeat (50) @(posedge pclk);
    duty(200, {16'd200, 16'd0, 16'd100, 16'd0}, "divider");
    apb(1'b1, 8'h00, 32'h1, 4'h1);
    repeat (4) @(posedge pclk);
    duty(200, {16'd0, 16'd0, 16'd0, 16'd100}, "route");
    apb(1'b1, 8'h04, 32'h0, 4'h1);
    repeat (50) @(posedge pclk);
    apb(1'b1, 8'h14, 32'h38, 4'h1);
    repeat (30) @(posedge pclk);
    duty(100, {16'd0, 16'd0, 16'd0, 16'd50}, "low byte");
    apb(1'b1, 8'h14, 32'h0, 4'h2);
    repeat (30) @(posedge pclk);
    duty(100, {16'd0, 16'd0, 16'd0, 16'd70}, "high byte");
    // Byte format: one lane-0 write loads a compare value
    apb(1'b1, 8'h04, 32'h10, 4'h1);
    apb(1'b1, 8'h14, 32'h03, 4'h1);
    repeat (30) @(posedge pclk);
    duty(100, {16'd0, 16'd0, 16'd0, 16'd30}, "fmt8");
    apb(1'b1, 8'h04, 32'h30, 4'h1);
    repeat (30) @(posedge pclk);
    rdchk(8'h04, 32'h10, "force cleared");
    $display("test force done");
    final_report;
  end
endmodule : tppg_core_tb_top
